// *** hw/diagnostic_status.sv ***
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Bit 6 shows die temperature above 125 C.
// - Bit 5 shows linear stage running alongside boost stage.
// - Bit 3 sets on a thermal shutdown event.
// - Bit 2 sets after over-current lasts beyond 48 ms; clears on release.
// - Latched thermal or over-current holds fault request low until released.
// - Bit 1 shows output current above 50 mA.
// - Bit 0 shows output voltage within range.
// - Bit 6, latched bit 3 or 2, or bit 0 clear (output out of range) pulls fault request low.
// - Other flags follow conditions without latching.
module diagnostic_status #(
  parameter logic [23:0] OC_LIMIT = 24'(diag_status_pkg::OC_PERSIST_CYCLES)
) (
  input  wire logic       clk,             // 200 MHz clock
  input  wire logic       rst,             // Async reset, active high
  input  wire logic       die_hot,         // Die above 125 C
  input  wire logic       linear_running,  // Linear regulator on
  input  wire logic       boost_running,   // Boost stage on
  input  wire logic       thermal_event,   // Thermal shutdown occurring
  input  wire logic       overcurrent,     // Over-current condition present
  input  wire logic       load_above_min,  // Output current above 50 mA
  input  wire logic       vout_in_range,   // Output voltage in range
  input  wire logic       rd_strobe,       // Register read pulse
  input  wire logic [7:0] rd_addr,         // Register read address
  input  wire logic       release_strobe,  // Host releases latched faults
  output logic      [7:0] rd_data,         // Read data, registered
  output logic            fault_request_n  // Active-low fault request
);
  // ---------------------------------------------------------------
  // Condition capture
  // ---------------------------------------------------------------
  logic       oc_expired;
  logic       tsd_q;
  logic       tsd_d;
  logic       ocf_q;
  logic       ocf_d;
  logic       read_seen_q;
  logic       read_seen_d;
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] rdat_d;
  logic       fault_d;

  persist_timer #(
    .LIMIT   (OC_LIMIT)
  ) u_oc_timer (
    .clk     (clk),
    .rst     (rst),
    .cond    (overcurrent),
    .expired (oc_expired)
  );

  // ---------------------------------------------------------------
  // Latches and status image
  // ---------------------------------------------------------------
  always_comb
  begin
    read_seen_d = read_seen_q;
    if (rd_strobe && rd_addr == diag_status_pkg::STATUS_OFFSET)
      read_seen_d = 1'b1;
    // Release only after a read and once conditions are gone; set wins
    tsd_d = tsd_q;
    ocf_d = ocf_q;
    if (release_strobe && read_seen_q)
    begin
      tsd_d       = 1'b0;
      ocf_d       = 1'b0;
      read_seen_d = 1'b0;
    end
    if (thermal_event)
      tsd_d = 1'b1;
    if (oc_expired)
      ocf_d = 1'b1;
    status_d = diag_status_pkg::STATUS_RESET;
    status_d[diag_status_pkg::BIT_OVERTEMP]     = die_hot;
    status_d[diag_status_pkg::BIT_LINEAR_ON]    = linear_running && boost_running;
    status_d[diag_status_pkg::BIT_THERMAL_SD]   = tsd_d;
    status_d[diag_status_pkg::BIT_OVERCURRENT]  = ocf_d;
    status_d[diag_status_pkg::BIT_LOAD_PRESENT] = load_above_min;
    status_d[diag_status_pkg::BIT_OUT_IN_RANGE] = vout_in_range;
    // Linear-on and in-range are normal states, not faults
    fault_d = ~(tsd_d | ocf_d | die_hot | ~vout_in_range);
    rdat_d  = rd_data;
    if (rd_strobe)
      rdat_d = (rd_addr == diag_status_pkg::STATUS_OFFSET) ? status_q : 8'h00;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tsd_q           <= 1'b0;
      ocf_q           <= 1'b0;
      read_seen_q     <= 1'b0;
      status_q        <= diag_status_pkg::STATUS_RESET;
      rd_data         <= 8'h00;
      fault_request_n <= 1'b1;
    end
    else
    begin
      tsd_q           <= tsd_d;
      ocf_q           <= ocf_d;
      read_seen_q     <= read_seen_d;
      status_q        <= status_d;
      rd_data         <= rdat_d;
      fault_request_n <= fault_d;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_tsd_set;
    @(posedge clk) disable iff (rst) thermal_event |=> status_q[3] && !fault_request_n;
  endproperty
  a_tsd_set: assert property (p_tsd_set) else $error("thermal flag not set");

  property p_oc_hold;
    @(posedge clk) disable iff (rst) ocf_q && !release_strobe |=> ocf_q;
  endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("overcurrent flag dropped");

  property p_oc_cause;
    @(posedge clk) disable iff (rst) $rose(ocf_q) |-> $past(overcurrent, 2);
  endproperty
  a_oc_cause: assert property (p_oc_cause) else $error("overcurrent flag without cause");

  property p_temp;
    @(posedge clk) disable iff (rst) die_hot |=> status_q[6];
  endproperty
  a_temp: assert property (p_temp) else $error("overtemp not reported");

  property p_linear;
    @(posedge clk) disable iff (rst) 1'b1 |=> status_q[5] == $past(linear_running && boost_running);
  endproperty
  a_linear: assert property (p_linear) else $error("linear flag wrong");

  property p_load;
    @(posedge clk) disable iff (rst) 1'b1 |=> status_q[1] == $past(load_above_min) && status_q[0] == $past(vout_in_range);
  endproperty
  a_load: assert property (p_load) else $error("load or range flag wrong");

  property p_reserved;
    @(posedge clk) disable iff (rst) status_q[7] == 1'b0 && status_q[4] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_fault_any;
    @(posedge clk) disable iff (rst) (tsd_q || ocf_q) |-> !fault_request_n;
  endproperty
  a_fault_any: assert property (p_fault_any) else $error("fault request not low");

  // ---------------------------------------------------------------
  // Check helpers
  // ---------------------------------------------------------------
  // Own run length, so the timer is not checked against itself
  logic [23:0] oc_run_q;
  logic [23:0] oc_run_d;

  always_comb
  begin
    oc_run_d = oc_run_q;
    if (!overcurrent)
      oc_run_d = 24'h000000;
    else if (oc_run_q != 24'hFFFFFF)
      oc_run_d = oc_run_q + 24'h000001;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      oc_run_q <= 24'h000000;
    else
      oc_run_q <= oc_run_d;
  end

  sequence s_release_taken;
    release_strobe && read_seen_q && !thermal_event && !oc_expired;
  endsequence

  sequence s_flags_quiet;
    !tsd_q && !ocf_q && !thermal_event && !oc_expired && !die_hot && vout_in_range;
  endsequence

  property p_release_clears;
    @(posedge clk) disable iff (rst) s_release_taken |=> !tsd_q && !ocf_q && !status_q[3] && !status_q[2];
  endproperty
  a_release_clears: assert property (p_release_clears) else $error("latched flags not released");

  property p_release_refused;
    @(posedge clk) disable iff (rst) release_strobe && !read_seen_q |=> !$fell(tsd_q) && !$fell(ocf_q);
  endproperty
  a_release_refused: assert property (p_release_refused) else $error("release taken without a read");

  property p_oc_latch;
    @(posedge clk) disable iff (rst) oc_expired |=> ocf_q && status_q[2] && !fault_request_n;
  endproperty
  a_oc_latch: assert property (p_oc_latch) else $error("overcurrent flag not latched");

  property p_oc_persist;
    @(posedge clk) disable iff (rst) $rose(ocf_q) |-> $past(oc_run_q, 2) >= OC_LIMIT;
  endproperty
  a_oc_persist: assert property (p_oc_persist) else $error("overcurrent flag too early");

  property p_fault_free;
    @(posedge clk) disable iff (rst) s_flags_quiet |=> fault_request_n;
  endproperty
  a_fault_free: assert property (p_fault_free) else $error("fault request stuck low");

  property p_fault_cond;
    @(posedge clk) disable iff (rst) die_hot || !vout_in_range |=> !fault_request_n;
  endproperty
  a_fault_cond: assert property (p_fault_cond) else $error("fault request missed a condition");

  property p_read_status;
    @(posedge clk) disable iff (rst)
      rd_strobe && rd_addr == diag_status_pkg::STATUS_OFFSET |=> rd_data == $past(status_q);
  endproperty
  a_read_status: assert property (p_read_status) else $error("status read wrong");

  property p_read_unmapped;
    @(posedge clk) disable iff (rst) rd_strobe && rd_addr != diag_status_pkg::STATUS_OFFSET |=> rd_data == 8'h00;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");
endmodule : diagnostic_status
`default_nettype wire

// *** hw/persist_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module persist_timer #(
  parameter logic [23:0] LIMIT = 24'h000010
) (
  input  wire logic clk,      // System clock
  input  wire logic rst,      // Async reset
  input  wire logic cond,     // Condition to time
  output logic      expired   // Condition lasted beyond LIMIT cycles
);
  logic [23:0] cnt_q;
  logic [23:0] cnt_d;
  logic        exp_d;

  always_comb
  begin
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (!cond)
      cnt_d = 24'h000000;
    else if (cnt_q < LIMIT)
      cnt_d = cnt_q + 24'h000001;
    else
      exp_d = 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q   <= 24'h000000;
      expired <= 1'b0;
    end
    else
    begin
      cnt_q   <= cnt_d;
      expired <= exp_d;
    end
  end
endmodule : persist_timer
`default_nettype wire

// *** shared/diag_status_pkg.sv ***
`default_nettype none
package diag_status_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] STATUS_OFFSET     = 8'h02;
  localparam logic [7:0] STATUS_RESET      = 8'h00;
  localparam int         BIT_OVERTEMP      = 6;
  localparam int         BIT_LINEAR_ON     = 5;
  localparam int         BIT_RESERVED      = 4;
  localparam int         BIT_THERMAL_SD    = 3;
  localparam int         BIT_OVERCURRENT   = 2;
  localparam int         BIT_LOAD_PRESENT  = 1;
  localparam int         BIT_OUT_IN_RANGE  = 0;
  localparam int         BIT_UNDEFINED     = 7;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int         CLK_PERIOD_PS     = 5000;
  localparam int         OC_PERSIST_MS     = 48;
  localparam longint     OC_PERSIST_CYCLES = (longint'(OC_PERSIST_MS) * 64'd1000000000) / CLK_PERIOD_PS;
  localparam int         OC_CNT_W          = 24;
endpackage : diag_status_pkg
`default_nettype wire

// *** verif/host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic       clk,            // System clock
  input  wire logic [7:0] rd_data,        // Read data from device
  output logic            rd_strobe,      // Read pulse
  output logic      [7:0] rd_addr,        // Read address
  output logic            release_strobe  // Release pulse
);
  initial
  begin
    rd_strobe = 1'b0;
    rd_addr = 8'h00;
    release_strobe = 1'b0;
  end
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rd_strobe = 1'b1;
    rd_addr = a;
    @(negedge clk);
    rd_strobe = 1'b0;
    // Released address shows a changed value, not the last one
    rd_addr = ~a;
    d = rd_data;
  endtask : rd
  // Caller reads the status register before this
  task rel;
    @(negedge clk);
    release_strobe = 1'b1;
    @(negedge clk);
    release_strobe = 1'b0;
  endtask : rel
endmodule : host_model
`default_nettype wire

// *** verif/test_lnb_status_fault_flags.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_lnb_status_fault_flags;
  logic clk = 1'b0, rst = 1'b1, hot = 1'b0, lin = 1'b0, bst = 1'b0;
  logic tev = 1'b0, oc = 1'b0, load = 1'b0, vin = 1'b1;
  wire logic       rd_strobe, release_strobe, fault_n;
  wire logic [7:0] rd_addr, rd_data;
  logic      [7:0] d;
  int              mismatches = 0;
  int              checked = 0;
  always #2.5 clk = ~clk;
  diagnostic_status #(.OC_LIMIT(24'h000010)) dut (.clk(clk), .rst(rst), .die_hot(hot), .linear_running(lin),
    .boost_running(bst), .thermal_event(tev), .overcurrent(oc), .load_above_min(load), .vout_in_range(vin),
    .rd_strobe(rd_strobe), .rd_addr(rd_addr), .release_strobe(release_strobe), .rd_data(rd_data),
    .fault_request_n(fault_n));
  host_model host (.clk(clk), .rd_data(rd_data), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
    .release_strobe(release_strobe));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task report_and_stop;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // Watchdog so a stuck run still ends in the report
  initial
  begin
    #100000;
    mismatches++;
    report_and_stop();
  end
  initial
  begin
    cyc(5);
    rst = 1'b0;
    host.rd(8'h02, d);
    chk(d, 8'h01);
    chk({7'h00, fault_n}, 8'h01);
    hot = 1'b1;
    lin = 1'b1;
    bst = 1'b1;
    load = 1'b1;
    host.rd(8'h02, d);
    chk(d, 8'h63);
    cyc(1);
    chk({7'h00, fault_n}, 8'h00);
    hot = 1'b0;
    lin = 1'b0;
    vin = 1'b0;
    host.rd(8'h02, d);
    chk(d, 8'h02);
    vin = 1'b1;
    tev = 1'b1;
    cyc(1);
    tev = 1'b0;
    host.rd(8'h02, d);
    chk(d, 8'h0B);
    cyc(1);
    chk({7'h00, fault_n}, 8'h00);
    host.rel();
    host.rd(8'h02, d);
    chk(d, 8'h03);
    cyc(1);
    chk({7'h00, fault_n}, 8'h01);
    oc = 1'b1;
    cyc(14);
    host.rd(8'h02, d);
    chk(d, 8'h03);
    // Last read whose image still predates the persistence limit
    host.rd(8'h02, d);
    chk(d, 8'h03);
    host.rd(8'h02, d);
    chk(d, 8'h07);
    oc = 1'b0;
    cyc(2);
    chk({7'h00, fault_n}, 8'h00);
    host.rd(8'h02, d);
    host.rel();
    // Release with no read since the last one must be ignored
    tev = 1'b1;
    cyc(1);
    tev = 1'b0;
    host.rel();
    cyc(1);
    chk({7'h00, fault_n}, 8'h00);
    host.rd(8'h02, d);
    chk(d, 8'h0B);
    host.rel();
    host.rd(8'h02, d);
    chk(d, 8'h03);
    cyc(1);
    chk({7'h00, fault_n}, 8'h01);
    host.rd(8'h05, d);
    chk(d, 8'h00);
    report_and_stop();
  end
endmodule : test_lnb_status_fault_flags
`default_nettype wire
